// ### logic/pahsb_packed_add.sv
module pahsb_packed_add
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_valid,
    input wire pahsb_pkg::pahsb_req_t i_req,
    output logic o_valid,
    output logic [127:0] o_result,
    output logic o_arith_exception
);

    logic [127:0] sum_next;
    logic [16:0] carry;
    logic half_mode;
    logic sat_mode;
    logic legal_op;
    logic [127:0] result_reg;
    logic valid_reg;
    logic exception_reg;

    assign half_mode = (i_req.op == pahsb_pkg::PAHSB_OP_HALF_WRAP);
    assign sat_mode = (i_req.op == pahsb_pkg::PAHSB_OP_BYTE_SAT);
    assign legal_op = half_mode || sat_mode;
    assign carry[0] = 1'b0;

    // Both modes share one adder per byte; the halfword mode chains pairs of them,
    // which costs one AND gate per odd byte instead of a second adder array.
    genvar g;
    generate
        for (g = 0; g < 16; g++)
        begin : g_lane
            logic chain_in;
            assign chain_in = (g % 2 == 1) ? (half_mode && carry[g]) : 1'b0;
            pahsb_byte_lane u_lane
            (
                .i_a(i_req.first_source_operand[g*8 +: 8]),
                .i_b(i_req.second_source_operand[g*8 +: 8]),
                .i_carry(chain_in),
                .i_saturate(sat_mode),
                .o_sum(sum_next[g*8 +: 8]),
                .o_carry(carry[g+1])
            );
        end
    endgenerate

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            result_reg <= pahsb_pkg::PAHSB_RESULT_RST;
        end
        else if (i_valid)
        begin
            // Undecoded op codes write zero rather than a half-formed sum
            result_reg <= legal_op ? sum_next : pahsb_pkg::PAHSB_RESULT_RST;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            valid_reg <= 1'b0;
        end
        else
        begin
            valid_reg <= i_valid;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            exception_reg <= 1'b0;
        end
        else
        begin
            exception_reg <= 1'b0;
        end
    end

    assign o_result = result_reg;
    assign o_valid = valid_reg;
    assign o_arith_exception = exception_reg;

    // Reference values that only the assertions and covers read
    logic [127:0] ref_half;
    logic [127:0] ref_sat;
    logic [15:0] ref_hi;
    logic [15:0] ref_lo;
    logic [15:0] ref_127;
    logic [15:0] ref_m128;

    generate
        for (g = 0; g < 8; g++)
        begin : g_ref_half
            assign ref_half[g*16 +: 16] =
                i_req.first_source_operand[g*16 +: 16]
                + i_req.second_source_operand[g*16 +: 16];
        end
        for (g = 0; g < 16; g++)
        begin : g_ref_sat
            logic signed [8:0] s;
            assign s = $signed({i_req.first_source_operand[g*8+7],
                                i_req.first_source_operand[g*8 +: 8]})
                     + $signed({i_req.second_source_operand[g*8+7],
                                i_req.second_source_operand[g*8 +: 8]});
            assign ref_hi[g] = (s > 9'sd127);
            assign ref_lo[g] = (s < -9'sd128);
            assign ref_127[g] = (s == 9'sd127);
            assign ref_m128[g] = (s == -9'sd128);
            assign ref_sat[g*8 +: 8] = s[7:0];
        end
    endgenerate

    a_valid_latency: assert property (
        @(posedge i_clk) disable iff (i_reset)
        i_valid |=> o_valid)
        else $error("result valid missing one cycle after request");

    a_idle_hold: assert property (
        @(posedge i_clk) disable iff (i_reset)
        !i_valid |=> !o_valid && $stable(o_result))
        else $error("result changed without a request");

    a_half_wrap: assert property (
        @(posedge i_clk) disable iff (i_reset)
        i_valid && half_mode |=> o_result == $past(ref_half))
        else $error("halfword wrap sum wrong");

    a_no_exception: assert property (
        @(posedge i_clk) disable iff (i_reset)
        !o_arith_exception)
        else $error("arithmetic exception raised");

    a_top_lane_used: assert property (
        @(posedge i_clk) disable iff (i_reset)
        i_valid && half_mode |=>
            o_result[127:112] == $past(ref_half[127:112]))
        else $error("top halfword lane not written");

    a_undef_zero: assert property (
        @(posedge i_clk) disable iff (i_reset)
        i_valid && !legal_op |=>
            o_result == pahsb_pkg::PAHSB_RESULT_RST)
        else $error("undecoded operation left a nonzero result");

    // Checked through reset too, so no stale sum survives a pipeline flush
    a_reset_clear: assert property (
        @(posedge i_clk)
        i_reset |=> !o_valid && o_result == pahsb_pkg::PAHSB_RESULT_RST)
        else $error("outputs not cleared by reset");

    generate
        for (g = 0; g < 16; g++)
        begin : g_chk
            a_sat_high: assert property (
                @(posedge i_clk) disable iff (i_reset)
                i_valid && sat_mode && ref_hi[g] |=>
                    o_result[g*8 +: 8] == 8'h7f)
                else $error("positive overflow not clamped");

            a_sat_low: assert property (
                @(posedge i_clk) disable iff (i_reset)
                i_valid && sat_mode && ref_lo[g] |=>
                    o_result[g*8 +: 8] == 8'h80)
                else $error("negative overflow not clamped");

            a_sat_pass: assert property (
                @(posedge i_clk) disable iff (i_reset)
                i_valid && sat_mode && !ref_hi[g] && !ref_lo[g] |=>
                    o_result[g*8 +: 8] == $past(ref_sat[g*8 +: 8]))
                else $error("in-range byte sum altered");

            a_edge_127: assert property (
                @(posedge i_clk) disable iff (i_reset)
                i_valid && sat_mode && ref_127[g] |=>
                    o_result[g*8 +: 8] == 8'h7f && !$past(ref_hi[g]))
                else $error("sum of 127 treated as clamp");

            a_edge_min: assert property (
                @(posedge i_clk) disable iff (i_reset)
                i_valid && sat_mode && ref_m128[g] |=>
                    o_result[g*8 +: 8] == 8'h80 && !$past(ref_lo[g]))
                else $error("sum of -128 treated as clamp");

            a_lane_signed: assert property (
                @(posedge i_clk) disable iff (i_reset)
                i_valid && sat_mode |=>
                    o_result[g*8 +: 8] == ($past(ref_hi[g]) ? 8'h7f :
                        $past(ref_lo[g]) ? 8'h80 :
                        $past(ref_sat[g*8 +: 8])))
                else $error("signed byte lane result wrong");
        end
    endgenerate

    c_half_op: cover property (
        @(posedge i_clk) disable iff (i_reset)
        i_valid && half_mode && carry[16] ##1 o_valid);

    c_sat_high: cover property (
        @(posedge i_clk) disable iff (i_reset)
        i_valid && sat_mode && ref_hi[0]);

    c_sat_low: cover property (
        @(posedge i_clk) disable iff (i_reset)
        i_valid && sat_mode && ref_lo[15]);

    c_back_to_back: cover property (
        @(posedge i_clk) disable iff (i_reset)
        i_valid && half_mode ##1 i_valid && sat_mode);

    c_sat_edge: cover property (
        @(posedge i_clk) disable iff (i_reset)
        i_valid && sat_mode && ref_127[14]);

endmodule : pahsb_packed_add

// ### logic/pahsb_pkg.sv
package pahsb_pkg;

    localparam int unsigned PAHSB_DATA_W = 128;
    localparam int unsigned PAHSB_BYTE_W = 8;
    localparam int unsigned PAHSB_HALF_W = 16;
    localparam int unsigned PAHSB_BYTE_LANES = 16;
    localparam int unsigned PAHSB_HALF_LANES = 8;

    localparam logic [7:0] PAHSB_BYTE_SAT_MAX = 8'h7f;
    localparam logic [7:0] PAHSB_BYTE_SAT_MIN = 8'h80;
    localparam logic [127:0] PAHSB_RESULT_RST = 128'h0;

    // One-hot operation select from decode
    typedef enum logic [1:0]
    {
        PAHSB_OP_HALF_WRAP = 2'b01,
        PAHSB_OP_BYTE_SAT = 2'b10
    } pahsb_op_t;

    typedef struct packed
    {
        pahsb_op_t op;
        logic [127:0] first_source_operand;
        logic [127:0] second_source_operand;
    } pahsb_req_t;

endpackage : pahsb_pkg

// ### logic/pahsb_byte_lane.sv
// One byte slice: carry chained for halfword wrap, clamped for signed sat
module pahsb_byte_lane
(
    input wire logic [7:0] i_a,
    input wire logic [7:0] i_b,
    input wire logic i_carry,
    input wire logic i_saturate,
    output logic [7:0] o_sum,
    output logic o_carry
);

    logic [8:0] raw;
    logic overflow;

    assign raw = {1'b0, i_a} + {1'b0, i_b} + {8'h00, i_carry};
    assign o_carry = raw[8];

    // Exact signed overflow: equal signs in, different sign out.
    // A sum of exactly 127 or -128 is in range and passes through.
    // exact overflow test
    assign overflow = (i_a[7] == i_b[7]) && (raw[7] != i_a[7]);

    always_comb
    begin
        o_sum = raw[7:0];
        if (i_saturate && overflow)
        begin
            o_sum = i_a[7] ? pahsb_pkg::PAHSB_BYTE_SAT_MIN
                           : pahsb_pkg::PAHSB_BYTE_SAT_MAX;
        end
    end

endmodule : pahsb_byte_lane

// ### bench/pahsb_issue_model.sv
// Issue side of the pipeline: presents one operation per high valid cycle
module pahsb_issue_model
(
    input wire logic i_clk,
    output logic o_valid,
    output pahsb_pkg::pahsb_req_t o_req
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        o_valid = 1'b0;
        o_req = '0;
    end
    task automatic issue(input logic [1:0] op, input logic [127:0] a,
        input logic [127:0] b);
        @(posedge i_clk);
        o_valid <= 1'b1;
        o_req <= '{pahsb_pkg::pahsb_op_t'(op), a, b};
    endtask : issue
    // Operands not qualified by valid are scrambled so stale values never help
    task automatic idle();
        @(posedge i_clk);
        o_valid <= 1'b0;
        o_req <= ~o_req;
    endtask : idle
endmodule : pahsb_issue_model

// ### bench/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic valid;
    pahsb_pkg::pahsb_req_t req;
    logic o_valid;
    logic [127:0] o_result;
    logic o_exc;
    logic [127:0] exp_q[$];
    int failures = 0;
    int samples_checked = 0;
    always #10 clk = ~clk;
    pahsb_issue_model i_pahsb_issue_model(.i_clk(clk), .o_valid(valid),
        .o_req(req));
    pahsb_packed_add i_pahsb_packed_add(.i_clk(clk), .i_reset(reset),
        .i_valid(valid), .i_req(req), .o_valid(o_valid),
        .o_result(o_result), .o_arith_exception(o_exc));
    function automatic logic [127:0] model(input logic [1:0] op,
        input logic [127:0] a, input logic [127:0] b);
        logic [127:0] r;
        logic signed [8:0] s;
        r = '0;
        for (int k = 0; k < 8; k++)
            if (op == 2'b01)
                r[16*k+:16] = a[16*k+:16] + b[16*k+:16];
        for (int k = 0; k < 16; k++)
        begin
            s = $signed({a[8*k+7], a[8*k+:8]})
                + $signed({b[8*k+7], b[8*k+:8]});
            if (op == 2'b10)
                r[8*k+:8] = s > 127 ? pahsb_pkg::PAHSB_BYTE_SAT_MAX :
                    s < -128 ? pahsb_pkg::PAHSB_BYTE_SAT_MIN : s[7:0];
        end
        return r;
    endfunction : model
    task automatic check(input logic [127:0] seen, input logic [127:0] want);
        samples_checked++;
        if (seen !== want)
        begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask : check
    task automatic send(input logic [1:0] op, input logic [127:0] a,
        input logic [127:0] b);
        exp_q.push_back(model(op, a, b));
        i_pahsb_issue_model.issue(op, a, b);
    endtask : send
    task automatic stop_test();
        $display("checked %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    // Each valid pulse consumes exactly one expected result
    always @(posedge clk)
    begin
        if (!reset)
            check({127'h0, o_exc}, 128'h0);
        if (o_valid === 1'b1 && exp_q.size() == 0)
            check({127'h0, o_valid}, 128'h0);
        else if (o_valid === 1'b1)
            check(o_result, exp_q.pop_front());
    end
    initial
    begin
        #100000;
        failures++;
        stop_test();
    end
    initial
    begin
        logic [127:0] a;
        logic [127:0] b;
        void'($urandom(86287));
        repeat (3) @(posedge clk);
        check(o_result, pahsb_pkg::PAHSB_RESULT_RST);
        check({126'h0, o_valid, o_exc}, 128'h0);
        reset <= 1'b0;
        send(2'b01, {8{16'hffff}}, {8{16'h0001}});
        send(2'b01, {8{16'h8000}}, {8{16'h8000}});
        a = 128'h7f7e_80c0_4081_01ff_007f_3f80_9c64_01fe;
        b = 128'h0101_ffc0_40ff_7e80_007f_4080_e41b_ff02;
        send(2'b10, a, b);
        send(2'b10, b, a);
        send(2'b01, a, b);
        send(2'b00, a, b);
        send(2'b11, a, b);
        i_pahsb_issue_model.idle();
        repeat (300)
        begin
            a = {$urandom, $urandom, $urandom, $urandom};
            b = {$urandom, $urandom, $urandom, $urandom};
            send(2'($urandom_range(3)), a, b);
            if ($urandom_range(3) == 0)
                i_pahsb_issue_model.idle();
        end
        i_pahsb_issue_model.idle();
        repeat (3) @(posedge clk);
        check(128'(exp_q.size()), 128'h0);
        stop_test();
    end
endmodule : tb
